// file: shared/itm_pkg.sv
// Purpose: Shared constants for the 12-bit interval timer block
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes: Narrow registers sit in the low bits, upper bits read as zero
package itm_pkg;

   // Register byte offsets
   localparam logic [7:0] ITM_OFS_CLK_EN = 8'h00;
   localparam logic [7:0] ITM_OFS_IFLAG = 8'h04;
   localparam logic [7:0] ITM_OFS_IMASK = 8'h08;
   localparam logic [7:0] ITM_OFS_CTRL = 8'h0C;
   localparam logic [7:0] ITM_OFS_SUBMODE = 8'h10;
   localparam logic [7:0] ITM_OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] ITM_OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] ITM_OFS_IRQ_EN = 8'h1C;
   localparam logic [7:0] ITM_OFS_COUNT = 8'h20;

   // Field positions
   localparam int ITM_BIT_SUPPLY_EN = 7;
   localparam int ITM_BIT_IRQ_FLAG = 2;
   localparam int ITM_BIT_IRQ_MASK = 2;
   localparam int ITM_BIT_RUN = 15;
   localparam int ITM_CMP_MSB = 11;
   localparam int ITM_BIT_LOW_POWER = 7;
   localparam int ITM_BIT_CLK_SEL = 4;
   localparam int ITM_EV_INTERVAL = 0;
   localparam int ITM_EV_CMP_ZERO = 1;
   localparam int ITM_EV_OVERRUN = 2;
   localparam int ITM_EV_NUM = 3;

   // Widths
   localparam int ITM_CNT_W = 12;

   // Reset values, and the prohibited zero compare
   localparam logic ITM_RST_SUPPLY_EN = 1'b0;
   localparam logic ITM_RST_IRQ_FLAG = 1'b0;
   localparam logic ITM_RST_IRQ_MASK = 1'b1;
   localparam logic ITM_RST_RUN = 1'b0;
   localparam logic [11:0] ITM_RST_CMP = 12'hFFF;
   localparam logic [11:0] ITM_CMP_ZERO = 12'h000;
   localparam logic ITM_RST_LOW_POWER = 1'b0;
   localparam logic ITM_RST_CLK_SEL = 1'b0;
   localparam logic [2:0] ITM_RST_EV = 3'h0;

   // Bus answer state
   typedef enum logic [0:0] {
      ITM_BUS_IDLE = 1'b0,
      ITM_BUS_ACK = 1'b1
   } itm_bus_type;

endpackage : itm_pkg

// file: rtl/itm_pin_sync.sv
// Purpose: Three-flop sampler and rising-edge finder for a foreign clock pin
// Assumes: Pin toggles well below half the system clock rate
// Notes: First flop feeds the second only
module itm_pin_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pin_i,
   output logic rise_o
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // Sampling chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else if (ce_i) begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Agreed level, updated only when flops two and three match
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_r <= 1'b0;
      end else if (ce_i && (s2_r == s3_r)) begin
         level_r <= s3_r;
      end
   end

   assign rise_o = ce_i && (s2_r == s3_r) && s3_r && !level_r;

endmodule : itm_pin_sync

// file: rtl/itm_counter.sv
// Purpose: Up counter with compare and clear for the interval timer
// Assumes: tick_i is a one-cycle pulse per count clock edge
// Notes: Period is compare value plus one ticks
module itm_counter #(
   parameter int CNT_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [CNT_W-1:0] cmp_i,
   output logic [CNT_W-1:0] count_o,
   output logic match_o
);

   logic [CNT_W-1:0] count_r;
   logic match_r;

   // Count upward, wrap on compare, clear while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else if (ce_i) begin
         if (!run_i) begin
            count_r <= '0;
         end else if (tick_i) begin
            if (count_r == cmp_i) begin
               count_r <= '0;
            end else begin
               count_r <= count_r + 1'b1;
            end
         end
      end
   end

   // One-cycle request on the wrapping tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_r <= 1'b0;
      end else if (ce_i) begin
         match_r <= run_i && tick_i && (count_r == cmp_i);
      end
   end

   assign count_o = count_r;
   assign match_o = match_r;

endmodule : itm_counter

// file: rtl/itm_interval_timer.sv
// Purpose: 12-bit interval timer with Wishbone registers and interrupt
// Assumes: Count clocks arrive as pins from other domains
// Notes: Registered ack, one wait state per access
module itm_interval_timer #(
   parameter int ADR_W = 8,
   parameter int CNT_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sub_clk_i,
   input wire logic lsosc_clk_i,
   input wire logic stop_mode_i,
   input wire logic halt_mode_i,
   input wire logic cpu_on_subclk_i,
   output logic subclk_periph_en_o,
   output logic interval_interrupt_o,
   output logic timer_irq_req_o,
   output logic irq_o
);

   // Bus state
   itm_pkg::itm_bus_type bus_r;
   itm_pkg::itm_bus_type bus_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic req;
   logic wr;
   logic [7:0] adr;

   // Register storage
   logic supply_en_r;
   logic irq_flag_r;
   logic irq_mask_r;
   logic run_r;
   logic [CNT_W-1:0] cmp_r;
   logic low_power_r;
   logic clk_sel_r;
   logic [itm_pkg::ITM_EV_NUM-1:0] ev_stat_r;
   logic [itm_pkg::ITM_EV_NUM-1:0] ev_en_r;
   logic interval_r;

   // Timer datapath
   logic sub_rise;
   logic lso_rise;
   logic sel_rise;
   logic tick;
   logic match;
   logic [CNT_W-1:0] count;
   logic [itm_pkg::ITM_EV_NUM-1:0] ev_set;
   logic [itm_pkg::ITM_EV_NUM-1:0] ev_clr;
   logic flag_clr;
   logic ctrl_lo_wr;
   logic ctrl_hi_wr;
   logic [CNT_W-1:0] cmp_wr_val;
   logic run_wr_val;

   // Request is taken on the first cycle only, ack follows one edge later
   assign req = wb_cyc_i && wb_stb_i && (bus_r == itm_pkg::ITM_BUS_IDLE);
   assign wr = req && wb_we_i;
   assign adr = 8'(wb_adr_i);

   // Bus answer state machine
   always_comb begin
      bus_nxt = bus_r;
      case (bus_r)
         itm_pkg::ITM_BUS_IDLE: begin
            if (req) begin
               bus_nxt = itm_pkg::ITM_BUS_ACK;
            end
         end
         itm_pkg::ITM_BUS_ACK: begin
            bus_nxt = itm_pkg::ITM_BUS_IDLE;
         end
         default: begin
            bus_nxt = itm_pkg::ITM_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_r <= itm_pkg::ITM_BUS_IDLE;
      end else if (ce_i) begin
         bus_r <= bus_nxt;
      end
   end

   assign wb_ack_o = (bus_r == itm_pkg::ITM_BUS_ACK);

   // Read data, captured with the request so it stands during ack
   always_comb begin
      dat_nxt = 32'h0000_0000;
      case (adr)
         itm_pkg::ITM_OFS_CLK_EN: begin
            dat_nxt[itm_pkg::ITM_BIT_SUPPLY_EN] = supply_en_r;
         end
         itm_pkg::ITM_OFS_IFLAG: begin
            dat_nxt[itm_pkg::ITM_BIT_IRQ_FLAG] = irq_flag_r;
         end
         itm_pkg::ITM_OFS_IMASK: begin
            dat_nxt[itm_pkg::ITM_BIT_IRQ_MASK] = irq_mask_r;
         end
         itm_pkg::ITM_OFS_CTRL: begin
            // Bits 14 to 12 stay zero
            dat_nxt[itm_pkg::ITM_BIT_RUN] = run_r;
            dat_nxt[itm_pkg::ITM_CMP_MSB:0] = cmp_r;
         end
         itm_pkg::ITM_OFS_SUBMODE: begin
            dat_nxt[itm_pkg::ITM_BIT_LOW_POWER] = low_power_r;
            dat_nxt[itm_pkg::ITM_BIT_CLK_SEL] = clk_sel_r;
         end
         itm_pkg::ITM_OFS_IRQ_STAT: begin
            dat_nxt[itm_pkg::ITM_EV_NUM-1:0] = ev_stat_r;
         end
         itm_pkg::ITM_OFS_IRQ_EN: begin
            dat_nxt[itm_pkg::ITM_EV_NUM-1:0] = ev_en_r;
         end
         itm_pkg::ITM_OFS_COUNT: begin
            dat_nxt[CNT_W-1:0] = count;
         end
         default: begin
            // Unmapped and write-only words read as zero
            dat_nxt = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else if (ce_i && req) begin
         dat_r <= wb_we_i ? 32'h0000_0000 : dat_nxt;
      end
   end

   assign wb_dat_o = dat_r;

   // Peripheral clock supply enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_en_r <= itm_pkg::ITM_RST_SUPPLY_EN;
      end else if (ce_i && wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_CLK_EN)) begin
         supply_en_r <= wb_dat_i[itm_pkg::ITM_BIT_SUPPLY_EN];
      end
   end

   // Control register byte lanes, low lane holds compare bits 7-0
   assign ctrl_lo_wr = wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_CTRL);
   assign ctrl_hi_wr = wr && wb_sel_i[1] && (adr == itm_pkg::ITM_OFS_CTRL);
   assign cmp_wr_val = {ctrl_hi_wr ? wb_dat_i[itm_pkg::ITM_CMP_MSB:8] : cmp_r[11:8],
                        ctrl_lo_wr ? wb_dat_i[7:0] : cmp_r[7:0]};
   assign run_wr_val = ctrl_hi_wr ? wb_dat_i[itm_pkg::ITM_BIT_RUN] : run_r;

   // Run bit and compare value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= itm_pkg::ITM_RST_RUN;
         cmp_r <= itm_pkg::ITM_RST_CMP;
      end else if (ce_i && (ctrl_lo_wr || ctrl_hi_wr)) begin
         run_r <= run_wr_val;
         cmp_r <= cmp_wr_val;
      end
   end

   // Subclock mode bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_power_r <= itm_pkg::ITM_RST_LOW_POWER;
         clk_sel_r <= itm_pkg::ITM_RST_CLK_SEL;
      end else if (ce_i && wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_SUBMODE)) begin
         low_power_r <= wb_dat_i[itm_pkg::ITM_BIT_LOW_POWER];
         clk_sel_r <= wb_dat_i[itm_pkg::ITM_BIT_CLK_SEL];
      end
   end

   // Interrupt mask, reset masked so nothing fires before setup
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= itm_pkg::ITM_RST_IRQ_MASK;
      end else if (ce_i && wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_IMASK)) begin
         irq_mask_r <= wb_dat_i[itm_pkg::ITM_BIT_IRQ_MASK];
      end
   end

   // Count clock pins, each through its own sampler
   itm_pin_sync u_sub_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(sub_clk_i),
      .rise_o(sub_rise)
   );

   itm_pin_sync u_lso_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(lsosc_clk_i),
      .rise_o(lso_rise)
   );

   // Count clock choice and supply gate
   assign sel_rise = clk_sel_r ? lso_rise : sub_rise;
   assign tick = supply_en_r && sel_rise;

   // Standby never gates the timer tick; only other peripherals lose the subclock
   assign subclk_periph_en_o = !(low_power_r &&
                                 (stop_mode_i || (halt_mode_i && cpu_on_subclk_i)));

   itm_counter #(
      .CNT_W(CNT_W)
   ) u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(run_r),
      .tick_i(tick),
      .cmp_i(cmp_r),
      .count_o(count),
      .match_o(match)
   );

   // Registered interval request pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interval_r <= 1'b0;
      end else if (ce_i) begin
         interval_r <= match;
      end
   end

   assign interval_interrupt_o = interval_r;

   // Request flag: hardware set beats a software clear in the same cycle
   assign flag_clr = wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_IFLAG) &&
                     !wb_dat_i[itm_pkg::ITM_BIT_IRQ_FLAG];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flag_r <= itm_pkg::ITM_RST_IRQ_FLAG;
      end else if (ce_i) begin
         if (match) begin
            irq_flag_r <= 1'b1;
         end else if (flag_clr) begin
            irq_flag_r <= 1'b0;
         end
      end
   end

   // Servicing only while unmasked
   assign timer_irq_req_o = irq_flag_r && !irq_mask_r;

   // Events for the sticky status word
   always_comb begin
      ev_set = '0;
      ev_set[itm_pkg::ITM_EV_INTERVAL] = match;
      // A prohibited zero compare still runs, wrapping on every tick
      ev_set[itm_pkg::ITM_EV_CMP_ZERO] = (ctrl_lo_wr || ctrl_hi_wr) &&
                                         (cmp_wr_val == itm_pkg::ITM_CMP_ZERO);
      ev_set[itm_pkg::ITM_EV_OVERRUN] = match && irq_flag_r;
   end

   assign ev_clr = (wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_IRQ_CLR)) ?
                   wb_dat_i[itm_pkg::ITM_EV_NUM-1:0] : '0;

   // Sticky status, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_stat_r <= itm_pkg::ITM_RST_EV;
      end else if (ce_i) begin
         ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
      end
   end

   // Event enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_en_r <= itm_pkg::ITM_RST_EV;
      end else if (ce_i && wr && wb_sel_i[0] && (adr == itm_pkg::ITM_OFS_IRQ_EN)) begin
         ev_en_r <= wb_dat_i[itm_pkg::ITM_EV_NUM-1:0];
      end
   end

   // Level interrupt line
   assign irq_o = |(ev_stat_r & ev_en_r);

endmodule : itm_interval_timer

// file: sim/itm_interval_timer_checker.sv
// Purpose: Port-level checks for the interval timer
// Assumes: Bus writes use all byte lanes
// Notes: Shadow bits track the control writes taken on the bus
module itm_interval_timer_checker #(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic stop_mode_i,
   input wire logic halt_mode_i,
   input wire logic cpu_on_subclk_i,
   input wire logic subclk_periph_en_o,
   input wire logic interval_interrupt_o,
   input wire logic timer_irq_req_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mask_r, run_r, sup_r, lp_r, wr;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & ce_i;
   // Shadows of mask, run, supply and low-power bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= itm_pkg::ITM_RST_IRQ_MASK;
         run_r <= itm_pkg::ITM_RST_RUN;
         sup_r <= itm_pkg::ITM_RST_SUPPLY_EN;
         lp_r <= itm_pkg::ITM_RST_LOW_POWER;
      end else if (wr) begin
         if (wb_adr_i == ADR_W'(itm_pkg::ITM_OFS_IMASK) && wb_sel_i[0]) mask_r <= wb_dat_i[2];
         if (wb_adr_i == ADR_W'(itm_pkg::ITM_OFS_CLK_EN) && wb_sel_i[0]) sup_r <= wb_dat_i[7];
         if (wb_adr_i == ADR_W'(itm_pkg::ITM_OFS_SUBMODE) && wb_sel_i[0]) lp_r <= wb_dat_i[7];
         if (wb_adr_i == ADR_W'(itm_pkg::ITM_OFS_CTRL) && wb_sel_i[1]) run_r <= wb_dat_i[15];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   intr_pulse_a: assert property (interval_interrupt_o |=> !interval_interrupt_o)
      else $error("interval pulse too long");
   req_follows_a: assert property (interval_interrupt_o && !mask_r && !wb_ack_o |-> timer_irq_req_o)
      else $error("request flag not set by interval");
   mask_blocks_a: assert property (mask_r |-> !timer_irq_req_o)
      else $error("request seen while masked");
   stop_quiet_a: assert property (!run_r [*3] |-> !interval_interrupt_o)
      else $error("interval while stopped");
   supply_quiet_a: assert property (!sup_r [*3] |-> !interval_interrupt_o)
      else $error("interval without clock supply");
   lp_gate_a: assert property (subclk_periph_en_o ==
      !(lp_r && (stop_mode_i || (halt_mode_i && cpu_on_subclk_i))))
      else $error("peripheral subclock gate wrong");
   // Main scenarios reached
   cover property (interval_interrupt_o);
   cover property (irq_o);
   cover property (!subclk_periph_en_o);
endmodule : itm_interval_timer_checker

bind itm_interval_timer itm_interval_timer_checker #(.ADR_W(ADR_W)) chk_i (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .stop_mode_i(stop_mode_i), .halt_mode_i(halt_mode_i),
   .cpu_on_subclk_i(cpu_on_subclk_i), .subclk_periph_en_o(subclk_periph_en_o),
   .interval_interrupt_o(interval_interrupt_o), .timer_irq_req_o(timer_irq_req_o),
   .irq_o(irq_o)
);

// file: sim/itm_interval_timer_tb.sv
// Purpose: Self-checking bench for the interval timer
// Assumes: Count pins come from a divider of the system clock
// Notes: Sub pin period 16 clocks, low-speed pin period 8 clocks
module itm_interval_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, halt = 1'b0, cpu = 1'b0, s;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, div = 4'h0;
   logic [31:0] dat = 32'h0, rd, wb_dat_o;
   logic wb_ack_o, sub_en, intv, req, irq;
   int n_errors = 0, tests_run = 0, per;

   always #4 clk_i = ~clk_i;
   // Slow count clocks, high and low for at least four cycles each
   always @(posedge clk_i) div <= div + 4'h1;

   itm_interval_timer itm_interval_timer_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .sub_clk_i(div[3]), .lsosc_clk_i(div[2]), .stop_mode_i(stop),
      .halt_mode_i(halt), .cpu_on_subclk_i(cpu), .subclk_periph_en_o(sub_en),
      .interval_interrupt_o(intv), .timer_irq_req_o(req), .irq_o(irq)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One classic cycle, held until ack is sampled
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      // A bus answer that never came counts as a mismatch
      check(32'(wb_ack_o), 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(rd, e);
   endtask : rdc

   // Cycles up to the next interval pulse, bounded
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (intv !== 1'b1 && n < 600);
   endtask : wait_pulse

   task automatic quiet(output logic q);
      q = 1'b0;
      repeat (100) begin
         @(posedge clk_i);
         if (intv === 1'b1) q = 1'b1;
      end
   endtask : quiet

   task automatic t_reset;
      rdc(itm_pkg::ITM_OFS_CLK_EN, 32'h0);
      rdc(itm_pkg::ITM_OFS_IMASK, 32'h4);
      rdc(itm_pkg::ITM_OFS_CTRL, 32'h0FFF);
      rdc(itm_pkg::ITM_OFS_SUBMODE, 32'h0);
      rdc(8'h30, 32'h0);
      wr(itm_pkg::ITM_OFS_CTRL, 32'hFFFF);
      rdc(itm_pkg::ITM_OFS_CTRL, 32'h8FFF);
      wr(itm_pkg::ITM_OFS_CTRL, 32'h0FFF);
   endtask : t_reset

   task automatic t_period;
      wr(itm_pkg::ITM_OFS_CLK_EN, 32'h80);
      wr(itm_pkg::ITM_OFS_IFLAG, 32'h0);
      wr(itm_pkg::ITM_OFS_IMASK, 32'h0);
      wr(itm_pkg::ITM_OFS_CTRL, 32'h8003);
      wait_pulse(per);
      wait_pulse(per);
      check(32'(per), 32'd64);
      check(32'(req), 32'h1);
      rdc(itm_pkg::ITM_OFS_IFLAG, 32'h4);
      wr(itm_pkg::ITM_OFS_IRQ_EN, 32'h1);
      check(32'(irq), 32'h1);
      wr(itm_pkg::ITM_OFS_IMASK, 32'h4);
      check(32'(req), 32'h0);
      // Stop first so no new interval re-sets what is cleared below
      wr(itm_pkg::ITM_OFS_CTRL, 32'h0003);
      wr(itm_pkg::ITM_OFS_IRQ_CLR, 32'h1);
      check(32'(irq), 32'h0);
      wr(itm_pkg::ITM_OFS_IFLAG, 32'h0);
      rdc(itm_pkg::ITM_OFS_IFLAG, 32'h0);
   endtask : t_period

   task automatic t_select;
      wr(itm_pkg::ITM_OFS_CTRL, 32'h8003);
      wr(itm_pkg::ITM_OFS_SUBMODE, 32'h10);
      repeat (3) wait_pulse(per);
      check(32'(per), 32'd32);
      wr(itm_pkg::ITM_OFS_SUBMODE, 32'h90);
      stop <= 1'b1;
      @(posedge clk_i);
      check(32'(sub_en), 32'h0);
      stop <= 1'b0;
      halt <= 1'b1;
      cpu <= 1'b1;
      @(posedge clk_i);
      check(32'(sub_en), 32'h0);
      cpu <= 1'b0;
      @(posedge clk_i);
      check(32'(sub_en), 32'h1);
      wr(itm_pkg::ITM_OFS_SUBMODE, 32'h0);
   endtask : t_select

   task automatic t_stop;
      wr(itm_pkg::ITM_OFS_CTRL, 32'h0003);
      rdc(itm_pkg::ITM_OFS_COUNT, 32'h0);
      quiet(s);
      check(32'(s), 32'h0);
      wr(itm_pkg::ITM_OFS_CLK_EN, 32'h0);
      wr(itm_pkg::ITM_OFS_CTRL, 32'h8003);
      quiet(s);
      check(32'(s), 32'h0);
      rdc(itm_pkg::ITM_OFS_COUNT, 32'h0);
   endtask : t_stop

   task automatic t_zero;
      wr(itm_pkg::ITM_OFS_CLK_EN, 32'h80);
      wr(itm_pkg::ITM_OFS_CTRL, 32'h8000);
      xfer(itm_pkg::ITM_OFS_IRQ_STAT, 1'b0, 32'h0);
      check(rd & 32'h2, 32'h2);
      repeat (3) wait_pulse(per);
      check(32'(per), 32'd16);
   endtask : t_zero

   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Main sequence after four reset cycles
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_period;
      t_select;
      t_stop;
      t_zero;
      conclude;
   end

   // Watchdog, well past the expected run of under a thousand cycles
   initial begin
      #200000;
      n_errors++;
      conclude;
   end
endmodule : itm_interval_timer_tb
